// ---- core/hvp_consts.vh ----
// Constants for the high voltage I/O protection and monitor block
`ifndef HVP_CONSTS_VH
`define HVP_CONSTS_VH

// System clock rate in MHz
`define HVP_CLK_MHZ            40

// Short-circuit qualification times and wake monoflop time, in microseconds
`define HVP_BUS_SHORT_US       20
`define HVP_AUX_SHORT_US       20
`define HVP_WAKE_SHORT_US      400
`define HVP_MONOFLOP_US        1300000

// Cycle counts: the times above at the clock rate, sized to the counters they load
`define HVP_BUS_SHORT_CYC      16'h0320
`define HVP_AUX_SHORT_CYC      16'h0320
`define HVP_WAKE_SHORT_CYC     16'h3E80
`define HVP_MONOFLOP_CYC       26'h3197500

// Command codes written to the interface command register
`define HVP_CMD_READ_CFG       8'h01
`define HVP_CMD_WRITE_CFG      8'h02
`define HVP_CMD_READ_MON       8'h03

// Protection configuration field positions
`define HVP_CFG_OPEN_DIAG      0
`define HVP_CFG_TMO_DIS        1
`define HVP_CFG_PASSIVE        2
`define HVP_CFG_REENABLE       3
`define HVP_CFG_READBACK       4

// Monitor field positions
`define HVP_MON_WAKE_SHORT     0
`define HVP_MON_AUX_SHORT      1
`define HVP_MON_BUS_SHORT      2
`define HVP_MON_LOW_VOLT       3
`define HVP_MON_BUF_EN         4
`define HVP_MON_AUX_PIN        5
`define HVP_MON_OVER_TEMP      6
`define HVP_MON_WAKE_PIN       7

// Reset values
`define HVP_CFG_RESET          5'h00
`define HVP_DATA_RESET         8'h00

`endif

// ---- core/hvp_short_filter.v ----
// Short-circuit duration filter: qualifies a raw short flag held long enough
module hvp_short_filter #(
    parameter [15:0] LIMIT = 16'h0320
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        rawShort,
    output reg         qualShort_ff
);

    reg  [15:0] cnt_ff;
    reg  [15:0] nxt_cnt;

    // Count while the raw short persists, saturate at the limit
    always @*
    begin
        if (!rawShort)
            nxt_cnt = 16'h0000;
        else if (cnt_ff == LIMIT)
            nxt_cnt = cnt_ff;
        else
            nxt_cnt = cnt_ff + 16'h0001;
    end

    // Glitches shorter than the limit never reach the status logic
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cnt_ff       <= 16'h0000;
            qualShort_ff <= 1'b0;
        end
        else
        begin
            cnt_ff       <= nxt_cnt;
            qualShort_ff <= rawShort && (cnt_ff == LIMIT);
        end
    end

endmodule

// ---- core/hvp_io_protect.v ----
// High voltage I/O protection control and live monitor behind a command/data pair
//
// Overview of operation
// R01 - Re-enable bit write restores all short-disabled pins; shorts qualified 20/400 us.
// R02 - Re-enable bit write also restores wake and aux pins after thermal shutdown.
// R03 - Short-circuit pending interrupt clears only on re-enable write, even after short ends.
// R04 - Re-enable bit clears itself after being written with one.
// R05 - Passive mode: bus short raises interrupt and status, driver stays active.
// R06 - Active mode: bus short raises interrupt, status, disables driver until re-enable.
// R07 - Timeout bit zero: wake pin deasserts 1.3 s after assertion; one disables it.
// R08 - Open-circuit diagnostic bit connects wake pin pull-up; clearing disconnects it.
// R09 - Eight-bit monitor is read-only, read through command, returned in data register.
// R10 - With readback enabled, monitor bits 7 and 5 show wake and aux pins.
// R11 - Monitor bit 6 reads one once a thermal shutdown occurred.
// R12 - Monitor bit 4 shows the voltage channel input buffer enable.
// R13 - Monitor bit 3, when enabled, is zero after supply low; rearm clears. The code sets bit 3 back to one on rearm.
// R14 - Monitor bit 2 set by bus short, cleared by re-enable write.
// R15 - Monitor bit 1 set by aux short, cleared by re-enable write.
// R16 - Monitor bit 0 shows a wake driver short-circuit.
// R17 - Readback enable bit: pin edges raise interrupt and readback bits become valid.
// R18 - Short durations are qualified by system clock counters before any action.
`include "hvp_consts.vh"

module hvp_io_protect #(
    parameter [15:0] WAKE_SHORT_CYC = `HVP_WAKE_SHORT_CYC,
    parameter [25:0] MONOFLOP_CYC   = `HVP_MONOFLOP_CYC
) (
    input  wire        mclk,
    input  wire        rst_b,
    // Command and data interface
    input  wire        cmdWe,
    input  wire [7:0]  cmdIn,
    input  wire        dataWe,
    input  wire [7:0]  dataIn,
    output reg  [7:0]  dataOut_ff,
    output reg         cmdDone_ff,
    // Raw analog indications
    input  wire        busShortRaw,
    input  wire        auxShortRaw,
    input  wire        wakeShortRaw,
    input  wire        thermalEvt,
    input  wire        wakePinIn,
    input  wire        auxPinIn,
    input  wire        vbufEnabled,
    input  wire        supplyLow,
    // Base configuration controls from outside this block
    input  wire        lowFlagEnable,
    input  wire        lowFlagRearm,
    input  wire        wakeAssert,
    input  wire        hvIrqEnable,
    // Driver and interrupt controls
    output reg         busDrvEn_ff,
    output reg         auxDrvEn_ff,
    output reg         wakeDrvEn_ff,
    output reg         wakeOut_ff,
    output reg         wakePullupEn_ff,
    output reg         hvInterruptLine_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [4:0]  cfg_ff;
    reg  [4:0]  nxt_cfg;
    reg  [7:0]  nxt_dataOut;
    reg         reEn_ff;
    reg         nxt_reEn;
    reg         busShortFlag_ff;
    reg         auxShortFlag_ff;
    reg         wakeShortFlag_ff;
    reg         overTemp_ff;
    reg         lowVoltOk_ff;
    reg         shortPend_ff;
    reg         busQualDly_ff;
    reg         auxQualDly_ff;
    reg         wakeQualDly_ff;
    reg         wakePinDly_ff;
    reg         auxPinDly_ff;
    reg         edgeSeen_ff;
    reg         wakeAssertDly_ff;
    reg         monoExpired_ff;
    reg  [25:0] monoCnt_ff;
    reg  [25:0] nxt_monoCnt;
    reg         nxt_monoExpired;
    reg  [7:0]  monitorVal;

    wire        busQual;
    wire        auxQual;
    wire        wakeQual;
    wire        busShortEvt;
    wire        auxShortEvt;
    wire        wakeShortEvt;
    wire        anyShortEvt;
    wire        readbackOn;
    wire        pinEdge;
    wire        passiveMode;
    wire        tmoDisabled;

    // Set-wins update of a sticky flag
    function sticky;
        input cur;
        input setEv;
        input clrEv;
        begin
            sticky = setEv | (cur & ~clrEv);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Short-circuit qualification

    // R18 duration counters
    hvp_short_filter #(
        .LIMIT        (`HVP_BUS_SHORT_CYC)
    ) u_busFilter (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .rawShort     (busShortRaw),
        .qualShort_ff (busQual)
    );

    hvp_short_filter #(
        .LIMIT        (`HVP_AUX_SHORT_CYC)
    ) u_auxFilter (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .rawShort     (auxShortRaw),
        .qualShort_ff (auxQual)
    );

    // R01 wake pin needs the longer qualification time
    hvp_short_filter #(
        .LIMIT        (WAKE_SHORT_CYC)
    ) u_wakeFilter (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .rawShort     (wakeShortRaw),
        .qualShort_ff (wakeQual)
    );

    // Rising edges of qualified shorts are the events; a held short acts once
    assign busShortEvt  = busQual & ~busQualDly_ff;
    assign auxShortEvt  = auxQual & ~auxQualDly_ff;
    assign wakeShortEvt = wakeQual & ~wakeQualDly_ff;
    assign anyShortEvt  = busShortEvt | auxShortEvt | wakeShortEvt;

    assign passiveMode  = cfg_ff[`HVP_CFG_PASSIVE];
    assign tmoDisabled  = cfg_ff[`HVP_CFG_TMO_DIS];
    assign readbackOn   = cfg_ff[`HVP_CFG_READBACK];

    ////////////////////////////////////////////////////////////////////////////
    // Command and data interface

    // Commands act in the cycle they are written; data writes only load the
    // data register, so a configuration write needs data first, then command
    always @*
    begin
        nxt_cfg     = cfg_ff;
        nxt_dataOut = dataOut_ff;
        nxt_reEn    = 1'b0;
        if (dataWe)
            nxt_dataOut = dataIn;
        if (cmdWe)
        begin
            case (cmdIn)
                `HVP_CMD_READ_CFG:
                begin
                    // R04 re-enable bit always reads back as zero
                    nxt_dataOut = {3'h0, cfg_ff[4], 1'b0, cfg_ff[2:0]};
                end
                `HVP_CMD_WRITE_CFG:
                begin
                    nxt_cfg  = {dataOut_ff[4], 1'b0, dataOut_ff[2:0]};
                    // R01 one-cycle re-enable pulse
                    nxt_reEn = dataOut_ff[`HVP_CFG_REENABLE];
                end
                `HVP_CMD_READ_MON:
                begin
                    // R09 monitor returned through the data register
                    nxt_dataOut = monitorVal;
                end
                default:
                begin
                    nxt_dataOut = nxt_dataOut;
                end
            endcase
        end
    end

    // Interface registers; the stored re-enable bit is never kept
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cfg_ff     <= `HVP_CFG_RESET;
            dataOut_ff <= `HVP_DATA_RESET;
            reEn_ff    <= 1'b0;
            cmdDone_ff <= 1'b0;
        end
        else
        begin
            cfg_ff     <= nxt_cfg;
            dataOut_ff <= nxt_dataOut;
            // R04 self-clearing pulse
            reEn_ff    <= nxt_reEn;
            cmdDone_ff <= cmdWe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and driver enables

    // A new short in the re-enable cycle wins, so no event is lost
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            busQualDly_ff    <= 1'b0;
            auxQualDly_ff    <= 1'b0;
            wakeQualDly_ff   <= 1'b0;
            busShortFlag_ff  <= 1'b0;
            auxShortFlag_ff  <= 1'b0;
            wakeShortFlag_ff <= 1'b0;
            overTemp_ff      <= 1'b0;
            shortPend_ff     <= 1'b0;
            busDrvEn_ff      <= 1'b1;
            auxDrvEn_ff      <= 1'b1;
            wakeDrvEn_ff     <= 1'b1;
        end
        else
        begin
            busQualDly_ff    <= busQual;
            auxQualDly_ff    <= auxQual;
            wakeQualDly_ff   <= wakeQual;
            // R14 bus short status
            busShortFlag_ff  <= sticky(busShortFlag_ff, busShortEvt, reEn_ff);
            // R15 aux short status
            auxShortFlag_ff  <= sticky(auxShortFlag_ff, auxShortEvt, reEn_ff);
            // R16 wake short status
            wakeShortFlag_ff <= sticky(wakeShortFlag_ff, wakeShortEvt, reEn_ff);
            // R11 thermal shutdown seen
            overTemp_ff      <= sticky(overTemp_ff, thermalEvt, reEn_ff);
            // R03 pending short interrupt cleared only by re-enable
            shortPend_ff     <= sticky(shortPend_ff, anyShortEvt, reEn_ff);
            // R05 R06 bus driver kept in passive mode, cut in active mode
            busDrvEn_ff      <= ~sticky(~busDrvEn_ff, busShortEvt & ~passiveMode, reEn_ff);
            // R01 R02 aux and wake drivers cut by short or thermal event
            auxDrvEn_ff      <= ~sticky(~auxDrvEn_ff, auxShortEvt | thermalEvt, reEn_ff);
            wakeDrvEn_ff     <= ~sticky(~wakeDrvEn_ff, wakeShortEvt | thermalEvt, reEn_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low voltage flag

    // R13 one means supply stayed good; a drop while enabled clears it and
    // only a rearm sets it again; a drop in the rearm cycle wins
    always @(posedge mclk)
    begin
        if (!rst_b)
            lowVoltOk_ff <= 1'b1;
        else if (lowFlagEnable && supplyLow)
            lowVoltOk_ff <= 1'b0;
        else if (lowFlagRearm)
            lowVoltOk_ff <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin readback edges and interrupt line

    // R17 edges count only while readback is enabled
    assign pinEdge = readbackOn & ((wakePinIn ^ wakePinDly_ff) | (auxPinIn ^ auxPinDly_ff));

    // The outer mask gates the line; the pending short holds it until re-enable
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            wakePinDly_ff      <= 1'b0;
            auxPinDly_ff       <= 1'b0;
            edgeSeen_ff        <= 1'b0;
            hvInterruptLine_ff <= 1'b0;
        end
        else
        begin
            wakePinDly_ff      <= wakePinIn;
            auxPinDly_ff       <= auxPinIn;
            // R17 edge interrupt pulse
            edgeSeen_ff        <= pinEdge;
            // R03 R05 R06 interrupt from short events
            hvInterruptLine_ff <= hvIrqEnable & (shortPend_ff | anyShortEvt | edgeSeen_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake monoflop

    // R07 count from the assertion edge; disabled counter never expires
    always @*
    begin
        nxt_monoCnt     = monoCnt_ff;
        nxt_monoExpired = monoExpired_ff;
        if (!wakeAssert || tmoDisabled)
        begin
            nxt_monoCnt     = 26'h0000000;
            nxt_monoExpired = 1'b0;
        end
        else if (!monoExpired_ff)
        begin
            if (monoCnt_ff == MONOFLOP_CYC - 26'h0000001)
                nxt_monoExpired = 1'b1;
            else
                nxt_monoCnt = monoCnt_ff + 26'h0000001;
        end
    end

    // Wake output follows the request unless timed out or its driver is cut
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            monoCnt_ff       <= 26'h0000000;
            monoExpired_ff   <= 1'b0;
            wakeAssertDly_ff <= 1'b0;
            wakeOut_ff       <= 1'b0;
            wakePullupEn_ff  <= 1'b0;
        end
        else
        begin
            monoCnt_ff       <= nxt_monoCnt;
            monoExpired_ff   <= nxt_monoExpired;
            wakeAssertDly_ff <= wakeAssert;
            // R07 timed deassertion
            wakeOut_ff       <= wakeAssert & wakeAssertDly_ff & ~nxt_monoExpired
                                & wakeDrvEn_ff;
            // R08 diagnostic pull-up follows its bit
            wakePullupEn_ff  <= nxt_cfg[`HVP_CFG_OPEN_DIAG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live monitor value

    // R09 read-only snapshot assembled at read time
    always @*
    begin
        monitorVal = 8'h00;
        // R10 pin readback bits
        monitorVal[`HVP_MON_WAKE_PIN]   = readbackOn & wakePinIn;
        monitorVal[`HVP_MON_AUX_PIN]    = readbackOn & auxPinIn;
        // R11 thermal bit
        monitorVal[`HVP_MON_OVER_TEMP]  = overTemp_ff;
        // R12 buffer enable bit
        monitorVal[`HVP_MON_BUF_EN]     = vbufEnabled;
        // R13 valid only when enabled
        monitorVal[`HVP_MON_LOW_VOLT]   = lowFlagEnable & lowVoltOk_ff;
        // R14 R15 R16 short status bits
        monitorVal[`HVP_MON_BUS_SHORT]  = busShortFlag_ff;
        monitorVal[`HVP_MON_AUX_SHORT]  = auxShortFlag_ff;
        monitorVal[`HVP_MON_WAKE_SHORT] = wakeShortFlag_ff;
    end

endmodule

// ---- test/hvp_io_protect_chk.sv ----
// Concurrent checks on the ports of the high voltage protection block
module hvp_io_protect_chk (
    input logic       mclk,
    input logic       rst_b,
    input logic       cmdWe,
    input logic [7:0] cmdIn,
    input logic [7:0] dataOut_ff,
    input logic       cmdDone_ff,
    input logic       busShortRaw,
    input logic       thermalEvt,
    input logic       vbufEnabled,
    input logic       wakeAssert,
    input logic       busDrvEn_ff,
    input logic       auxDrvEn_ff,
    input logic       wakeDrvEn_ff,
    input logic       wakeOut_ff,
    input logic       wakePullupEn_ff,
    input logic       hvInterruptLine_ff
);
    logic [9:0] busCnt_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // Run length of the raw bus short; saturates so a stuck short never wraps
    always_ff @(posedge mclk)
    begin
        if (!rst_b || !busShortRaw)
            busCnt_ff <= 10'h000;
        else if (busCnt_ff != 10'h3FF)
            busCnt_ff <= busCnt_ff + 10'h001;
    end
    ////////////////////////////////////////
    // Command handshake
    AST_DONE: assert property (cmdWe |=> cmdDone_ff)
        else $error("no done pulse after a command");
    AST_NODONE: assert property (!cmdWe |=> !cmdDone_ff)
        else $error("done pulse without a command");
    // Read paths
    AST_RDCFG: assert property (cmdWe && cmdIn == 8'h01 |=>
        dataOut_ff[7:5] == 3'h0 && !dataOut_ff[3]) else $error("config readback bits wrong");
    AST_BUF: assert property (cmdWe && cmdIn == 8'h03 |=>
        dataOut_ff[4] == $past(vbufEnabled)) else $error("buffer bit wrong");
    AST_OVERT: assert property (thermalEvt ##1 (cmdWe && cmdIn == 8'h03) |=>
        dataOut_ff[6]) else $error("overtemperature bit missing");
    // Short filter must see the whole qualification time before acting
    AST_BUSCNT: assert property ($fell(busDrvEn_ff) |-> busCnt_ff >= 10'h320)
        else $error("bus driver dropped before short was qualified");
    AST_THERM: assert property (thermalEvt |=> !auxDrvEn_ff && !wakeDrvEn_ff)
        else $error("thermal event left a driver on");
    AST_REEN: assert property ((cmdWe && cmdIn == 8'h02 && dataOut_ff[3] && !thermalEvt)
        ##1 !thermalEvt |=> busDrvEn_ff && auxDrvEn_ff && wakeDrvEn_ff)
        else $error("re-enable did not restore drivers");
    AST_PULLUP: assert property (cmdWe && cmdIn == 8'h02 |=>
        {7'h00, wakePullupEn_ff} == ($past(dataOut_ff) & 8'h01)) else $error("pull-up wrong");
    // Wake monoflop edges
    AST_WAKERISE: assert property ($rose(wakeAssert) && wakeDrvEn_ff |->
        ##2 (wakeOut_ff || !wakeAssert)) else $error("wake output late");
    AST_WAKEDROP: assert property (!wakeAssert |=> !wakeOut_ff)
        else $error("wake output stayed high");
    COV_BUSOFF: cover property ($fell(busDrvEn_ff));
    COV_PASSIVE: cover property (hvInterruptLine_ff && busDrvEn_ff && busShortRaw);
    COV_MONO: cover property ($fell(wakeOut_ff) && wakeAssert);
endmodule

// ---- test/hvp_line_model.sv ----
// Behavioural model of the external bus, auxiliary and wake lines
module hvp_line_model (
    input  logic busReq,
    input  logic auxReq,
    input  logic wakeReq,
    input  logic extWake,
    input  logic extAux,
    input  logic busDrvEn,
    input  logic auxDrvEn,
    input  logic wakeDrvEn,
    input  logic wakeOut,
    input  logic wakePullupEn,
    output logic busShortRaw,
    output logic auxShortRaw,
    output logic wakeShortRaw,
    output logic wakePinIn,
    output logic auxPinIn
);
    // short current flows only while the driver conducts
    assign busShortRaw  = busReq & busDrvEn;
    assign auxShortRaw  = auxReq & auxDrvEn;
    assign wakeShortRaw = wakeReq & wakeDrvEn;
    // wake line: external drive, own driver or pull-up; else pulled low
    assign wakePinIn = extWake | (wakeDrvEn & wakeOut) | wakePullupEn;
    assign auxPinIn  = extAux;
endmodule

// ---- test/tb_hvp_io_protect.sv ----
// Self-checking bench for the high voltage protection and monitor block
module tb_hvp_io_protect;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0, rst_b = 1'b0, cmdWe = 1'b0, dataWe = 1'b0;
    logic [7:0] cmdIn = 8'h00, dataIn = 8'h00;
    logic       thermalEvt = 1'b0, vbufEnabled = 1'b0, supplyLow = 1'b0;
    logic       lowFlagEnable = 1'b0, lowFlagRearm = 1'b0, wakeAssert = 1'b0;
    logic       hvIrqEnable = 1'b1, busReq = 1'b0, auxReq = 1'b0, wakeReq = 1'b0;
    logic       extWake = 1'b0, extAux = 1'b0;
    logic [7:0] dataOut_ff;
    logic       cmdDone_ff, busDrvEn_ff, auxDrvEn_ff, wakeDrvEn_ff, wakeOut_ff;
    logic       wakePullupEn_ff, hvInterruptLine_ff;
    logic       busShortRaw, auxShortRaw, wakeShortRaw, wakePinIn, auxPinIn;
    int         n_fail = 0;
    int         checks = 0;
    ////////////////////////////////////////
    // Short counts cut down so the wake filter and monoflop finish quickly
    hvp_io_protect #(.WAKE_SHORT_CYC(16'h0014), .MONOFLOP_CYC(26'h0000032)) hvp_io_protect_inst (
        .mclk, .rst_b, .cmdWe, .cmdIn, .dataWe, .dataIn, .dataOut_ff, .cmdDone_ff,
        .busShortRaw, .auxShortRaw, .wakeShortRaw, .thermalEvt, .wakePinIn, .auxPinIn,
        .vbufEnabled, .supplyLow, .lowFlagEnable, .lowFlagRearm, .wakeAssert, .hvIrqEnable,
        .busDrvEn_ff, .auxDrvEn_ff, .wakeDrvEn_ff, .wakeOut_ff, .wakePullupEn_ff,
        .hvInterruptLine_ff);
    hvp_line_model hvp_line_model_inst (.busReq, .auxReq, .wakeReq, .extWake, .extAux,
        .busDrvEn(busDrvEn_ff), .auxDrvEn(auxDrvEn_ff), .wakeDrvEn(wakeDrvEn_ff),
        .wakeOut(wakeOut_ff), .wakePullupEn(wakePullupEn_ff), .busShortRaw, .auxShortRaw,
        .wakeShortRaw, .wakePinIn, .auxPinIn);
    ////////////////////////////////////////
    // Clock at 40 MHz
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs move on the falling edge; a spare cycle keeps back to back strobes apart
    task automatic rd(input logic [7:0] code);
        cmdIn = code;
        cmdWe = 1'b1;
        @(negedge mclk);
        cmdWe = 1'b0;
        @(negedge mclk);
    endtask
    // Load data register, then write config; two spare cycles for the re-enable
    task automatic wr(input logic [7:0] v);
        dataIn = v;
        dataWe = 1'b1;
        @(negedge mclk);
        dataWe = 1'b0;
        rd(8'h02);
        repeat (2) @(negedge mclk);
    endtask
    ////////////////////////////////////////
    task automatic test_idle();
        rd(8'h01);
        chk(dataOut_ff, 8'h00);
        rd(8'h03);
        chk(dataOut_ff, 8'h00);
        cmdIn = 8'h55;
        cmdWe = 1'b1;
        @(negedge mclk);
        cmdWe = 1'b0;
        chk({7'h00, cmdDone_ff}, 8'h01);
        @(negedge mclk);
        chk({7'h00, cmdDone_ff}, 8'h00);
        chk({5'h00, busDrvEn_ff, auxDrvEn_ff, wakeDrvEn_ff}, 8'h07);
    endtask
    task automatic test_bus(input logic passive);
        wr({5'h00, passive, 2'h0});
        busReq = 1'b1;
        repeat (780) @(negedge mclk);
        chk({7'h00, busDrvEn_ff}, 8'h01);
        repeat (70) @(negedge mclk);
        chk({7'h00, busDrvEn_ff}, {7'h00, passive});
        chk({7'h00, hvInterruptLine_ff}, 8'h01);
        rd(8'h03);
        chk(dataOut_ff & 8'h04, 8'h04);
        busReq = 1'b0;
        repeat (3) @(negedge mclk);
        chk({7'h00, hvInterruptLine_ff}, 8'h01);
        wr({5'h01, passive, 2'h0});
        chk({6'h00, busDrvEn_ff, hvInterruptLine_ff}, 8'h02);
        rd(8'h03);
        chk(dataOut_ff & 8'h04, 8'h00);
        rd(8'h01);
        chk(dataOut_ff, {5'h00, passive, 2'h0});
    endtask
    // Interrupt masked: flags still set, line stays quiet
    task automatic test_aux_wake();
        hvIrqEnable = 1'b0;
        auxReq = 1'b1;
        wakeReq = 1'b1;
        repeat (850) @(negedge mclk);
        chk({5'h00, auxDrvEn_ff, wakeDrvEn_ff, hvInterruptLine_ff}, 8'h00);
        rd(8'h03);
        chk(dataOut_ff & 8'h03, 8'h03);
        auxReq = 1'b0;
        wakeReq = 1'b0;
        hvIrqEnable = 1'b1;
        wr(8'h08);
        chk({6'h00, auxDrvEn_ff, wakeDrvEn_ff}, 8'h03);
        rd(8'h03);
        chk(dataOut_ff & 8'h03, 8'h00);
    endtask
    task automatic test_thermal();
        thermalEvt = 1'b1;
        @(negedge mclk);
        thermalEvt = 1'b0;
        chk({6'h00, auxDrvEn_ff, wakeDrvEn_ff}, 8'h00);
        rd(8'h03);
        chk(dataOut_ff & 8'h40, 8'h40);
        wr(8'h08);
        chk({6'h00, auxDrvEn_ff, wakeDrvEn_ff}, 8'h03);
    endtask
    task automatic test_readback();
        logic hit;
        hit = 1'b0;
        extWake = 1'b1;
        extAux = 1'b1;
        rd(8'h03);
        chk(dataOut_ff & 8'hA0, 8'h00);
        wr(8'h10);
        rd(8'h03);
        chk(dataOut_ff & 8'hA0, 8'hA0);
        extWake = 1'b0;
        repeat (4)
        begin
            @(negedge mclk);
            hit = hit | hvInterruptLine_ff;
        end
        chk({7'h00, hit}, 8'h01);
        extAux = 1'b0;
        rd(8'h03);
        chk(dataOut_ff & 8'hA0, 8'h00);
        wr(8'h00);
    endtask
    task automatic test_levels();
        vbufEnabled = 1'b1;
        lowFlagEnable = 1'b1;
        rd(8'h03);
        chk(dataOut_ff & 8'h18, 8'h18);
        supplyLow = 1'b1;
        @(negedge mclk);
        supplyLow = 1'b0;
        rd(8'h03);
        chk(dataOut_ff & 8'h18, 8'h10);
        lowFlagRearm = 1'b1;
        @(negedge mclk);
        lowFlagRearm = 1'b0;
        vbufEnabled = 1'b0;
        rd(8'h03);
        chk(dataOut_ff & 8'h18, 8'h08);
    endtask
    task automatic test_wake();
        wr(8'h01);
        chk({6'h00, wakePullupEn_ff, wakePinIn}, 8'h03);
        wakeAssert = 1'b1;
        repeat (3) @(negedge mclk);
        chk({7'h00, wakeOut_ff}, 8'h01);
        repeat (60) @(negedge mclk);
        chk({7'h00, wakeOut_ff}, 8'h00);
        wakeAssert = 1'b0;
        wr(8'h02);
        chk({7'h00, wakePullupEn_ff}, 8'h00);
        wakeAssert = 1'b1;
        repeat (100) @(negedge mclk);
        chk({7'h00, wakeOut_ff}, 8'h01);
        wakeAssert = 1'b0;
        repeat (2) @(negedge mclk);
        chk({7'h00, wakeOut_ff}, 8'h00);
    endtask
    ////////////////////////////////////////
    // Main sequence; reset held three cycles
    initial
    begin
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        test_idle();
        test_bus(1'b0);
        test_bus(1'b1);
        test_aux_wake();
        test_thermal();
        test_readback();
        test_levels();
        test_wake();
        report_and_stop();
    end
    // Watchdog well beyond the roughly 2800 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        report_and_stop();
    end
endmodule
bind hvp_io_protect hvp_io_protect_chk hvp_io_protect_chk_inst (.mclk, .rst_b, .cmdWe, .cmdIn,
    .dataOut_ff, .cmdDone_ff, .busShortRaw, .thermalEvt, .vbufEnabled, .wakeAssert,
    .busDrvEn_ff, .auxDrvEn_ff, .wakeDrvEn_ff, .wakeOut_ff, .wakePullupEn_ff,
    .hvInterruptLine_ff);
